// ### verif/two_wire_register_slave_tb.sv
// Purpose: Bench joining master and slave ends.
// Assumes: 10 MHz mclk; second link clocked by the bench.
// Notes:   Second slave sees bench-made frames.
`timescale 1ns/10ps
`default_nettype none
`include "tws_map.svh"
module two_wire_register_slave_tb;
   logic        mclk, reset_n, req, rnw, ready, done, nack, ack, scl_q, sda_q, busy;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata;
   logic        stb [2];
   logic [7:0]  sa [2];
   logic [15:0] sd [2];
   logic [23:0] wq [$];
   logic [8:0]  mq [$];
   logic [8:0]  sh;
   int          nb, error_cnt, checks_done;
   tws_if bus ();
   tws_if bus2 ();
   tws_master u_tws_master (.mclk(mclk), .reset_n(reset_n), .bus(bus.master), .req(req),
      .rnw(rnw), .addr(addr), .wdata(wdata), .ready(ready), .done(done), .nack(nack),
      .rdata(rdata));
   tws_slave u_tws_slave (.mclk(mclk), .reset_n(reset_n), .bus(bus.slave), .wr_stb(stb[0]),
      .wr_addr(sa[0]), .wr_data(sd[0]), .busy(busy));
   tws_slave u_tws_slave_2 (.mclk(mclk), .reset_n(reset_n), .bus(bus2.slave),
      .wr_stb(stb[1]), .wr_addr(sa[1]), .wr_data(sd[1]), .busy());
   tws_link_checker u_tws_link_checker (.mclk(mclk), .reset_n(reset_n), .scl(bus.scl),
      .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe), .sda(bus.sda));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Collects write strobes of both slaves and bytes seen on the first link
   always @(negedge mclk) begin
      if (stb[0] === 1'b1) wq.push_back({sa[0], sd[0]});
      if (stb[1] === 1'b1) wq.push_back({sa[1], sd[1]});
      if (scl_q && bus.scl && sda_q && !bus.sda) nb = 0;
      else if (bus.scl && !scl_q) begin
         sh = {sh[7:0], bus.sda};
         nb++;
         if (nb == 9) begin
            mq.push_back(sh);
            nb = 0;
         end
      end
      scl_q = bus.scl;
      sda_q = bus.sda;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [44:0] got, input logic [44:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_wire(input int n, input logic [44:0] e);
      chk(mq.size(), n);
      for (int i = 0; i < n; i++) chk(mq[i], e[9*(n-1-i) +: 9]);
   endtask
   task automatic xfer(input logic r, input logic [7:0] a, input logic [15:0] d);
      int n;
      mq.delete();
      wq.delete();
      n = 0;
      req = 1'b1;
      rnw = r;
      addr = a;
      wdata = d;
      do begin
         @(posedge mclk);
         n++;
      end while (ready !== 1'b1 && n < 100);
      @(negedge mclk);
      req = 1'b0;
      while (done !== 1'b1 && n < 9000) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 9000) begin
         error_cnt++;
         $display("mismatch %0t no done", $time);
         summarize();
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Long low phase: the slave needs about five cycles to move its data
   task automatic bb_bit(input logic b, output logic r);
      tick(1);
      bus2.sda_m_oe = ~b;
      tick(5);
      bus2.scl = 1'b1;
      tick(2);
      r = bus2.sda;
      bus2.scl = 1'b0;
   endtask
   task automatic bb_byte(input logic [7:0] b, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--) bb_bit(b[i], r);
      bb_bit(1'b1, r);
      a = ~r;
   endtask
   task automatic bb_start();
      bus2.sda_m_oe = 1'b1;
      tick(4);
      bus2.scl = 1'b0;
   endtask
   task automatic bb_stop();
      tick(1);
      bus2.sda_m_oe = 1'b1;
      tick(5);
      bus2.scl = 1'b1;
      tick(4);
      bus2.sda_m_oe = 1'b0;
      tick(4);
   endtask
   task automatic bb_rstart();
      tick(1);
      bus2.sda_m_oe = 1'b0;
      tick(5);
      bus2.scl = 1'b1;
      tick(4);
      bb_start();
   endtask
   task automatic bb_rd(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bb_bit(1'b1, r);
         d = {d[6:0], r};
      end
      bb_bit(last, r);
   endtask
   task automatic t_write();
      xfer(1'b0, 8'h10, 16'ha55a);
      chk_wire(4, {`TWS_DEV_ADDR, `TWS_WR_BIT, 1'b0, 8'h10, 1'b0, 8'ha5, 1'b0, 8'h5a,
         1'b0});
      chk(wq.size(), 1);
      chk(wq[0], {8'h10, 16'ha55a});
      chk(nack, 1'b0);
      chk(busy, 1'b0);
      xfer(1'b0, 8'h11, 16'h0ff0);
      chk(wq[0], {8'h11, 16'h0ff0});
      $display("write test done");
   endtask
   task automatic t_read();
      xfer(1'b1, 8'h10, 16'h0000);
      chk(rdata, 16'ha55a);
      chk(nack, 1'b0);
      chk_wire(5, {`TWS_DEV_ADDR, `TWS_WR_BIT, 1'b0, 8'h10, 1'b0, `TWS_DEV_ADDR, `TWS_RD_BIT,
         1'b0, 8'ha5, 1'b0, 8'h5a, 1'b1});
      xfer(1'b1, 8'h11, 16'h0000);
      chk(rdata, 16'h0ff0);
      $display("read test done");
   endtask
   task automatic t_burst();
      logic [7:0] rd;
      wq.delete();
      bb_start();
      bb_byte({`TWS_DEV_ADDR ^ 7'h7f, `TWS_WR_BIT}, ack);
      chk(ack, 1'b0);
      bb_stop();
      bb_start();
      bb_byte({`TWS_DEV_ADDR, `TWS_WR_BIT}, ack);
      chk(ack, 1'b1);
      bb_byte(8'h3f, ack);
      chk(ack, 1'b1);
      for (int i = 0; i < 4; i++) begin
         bb_byte(8'hc3 + 8'h11 * i[7:0], ack);
         chk(ack, 1'b1);
      end
      bb_stop();
      chk(wq.size(), 2);
      chk(wq[0], {8'h3f, 16'hc3d4});
      chk(wq[1], {8'h40, 16'he5f6});
      bb_start();
      bb_byte({`TWS_DEV_ADDR, `TWS_WR_BIT}, ack);
      bb_byte(8'h3f, ack);
      chk(ack, 1'b1);
      bb_rstart();
      bb_byte({`TWS_DEV_ADDR, `TWS_RD_BIT}, ack);
      chk(ack, 1'b1);
      for (int i = 0; i < 4; i++) begin
         bb_rd(i == 3, rd);
         chk(rd, 8'hc3 + 8'h11 * i[7:0]);
      end
      bb_stop();
      chk(bus2.sda_s_oe, 1'b0);
      $display("burst test done");
   endtask
   initial begin
      {reset_n, req, rnw, addr, wdata, nb, error_cnt, checks_done} = '0;
      scl_q = 1'b1;
      sda_q = 1'b1;
      bus2.scl = 1'b1;
      bus2.sda_m_oe = 1'b0;
      tick(12);
      reset_n = 1'b1;
      t_write();
      t_read();
      t_burst();
      summarize();
   end
endmodule
`default_nettype wire

// ### verif/tws_link_checker.sv
// Purpose: Wire checks on the master-slave link.
// Assumes: mclk far faster than scl.
// Notes:   Sits beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module tws_link_checker (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic scl,
   input wire logic sda_m_oe,
   input wire logic sda_s_oe,
   input wire logic sda
);
   logic [5:0] nbit_r;
   logic       rd_r;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // Counts clock rises since the last start
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         nbit_r <= 6'h00;
         rd_r   <= 1'b0;
      end else if (scl && $past(scl) && $fell(sda)) begin
         nbit_r <= 6'h00;
      end else if ($rose(scl)) begin
         nbit_r <= nbit_r + 6'h01;
         if (nbit_r == 6'h07) begin
            rd_r <= sda;
         end
      end
   end
   a_start_by_master: assert property (scl && $past(scl) && $fell(sda) |-> sda_m_oe)
      else $error("start not made by master");
   a_addr_ack: assert property ($rose(scl) && nbit_r == 6'h08 |-> sda_s_oe)
      else $error("address not acknowledged");
   a_reg_ack: assert property ($rose(scl) && !rd_r && nbit_r == 6'h11 |-> sda_s_oe)
      else $error("register byte not acknowledged");
   a_wdata_ack: assert property ($rose(scl) && !rd_r && (nbit_r == 6'h1a || nbit_r == 6'h23)
      |-> sda_s_oe)
      else $error("data byte not acknowledged");
   a_read_dir: assert property ($rose(scl) && rd_r && nbit_r inside {[6'h09:6'h10]}
      |-> !sda_m_oe)
      else $error("master drives during read data");
   a_master_ack: assert property ($rose(scl) && rd_r && nbit_r == 6'h11 |-> !sda_s_oe)
      else $error("slave holds data in master ack slot");
   a_nack_release: assert property ($rose(scl) && rd_r && nbit_r == 6'h1a && sda
      |-> ##60 !sda_s_oe)
      else $error("slave drives after not-acknowledge");
   a_single_pull: assert property (scl && $past(scl, 4) |-> !(sda_m_oe && sda_s_oe))
      else $error("both ends pull data");
   a_slave_release: assert property ($rose(sda_s_oe) |-> ##[1:700] !sda_s_oe)
      else $error("slave holds data line too long");
   a_stop_idle: assert property (scl && $past(scl) && $rose(sda) |=> scl [*8])
      else $error("clock moves right after stop");
   c_start: cover property (scl && $past(scl) && $fell(sda));
   c_slave_pull: cover property ($rose(sda_s_oe));
   c_read_nack: cover property ($rose(scl) && rd_r && nbit_r == 6'h1a && sda);
endmodule
`default_nettype wire

// ### verilog/tws_if.sv
// Purpose: Two-wire link between master and slave.
// Assumes: Open-drain data, master-driven clock.
// Notes:   Wire level resolved from enables.
`timescale 1ns/10ps
`default_nettype none
interface tws_if;
   logic scl;
   logic sda_m_oe;
   logic sda_s_oe;
   logic sda;
   assign sda = ~(sda_m_oe | sda_s_oe);
   modport master (output scl, output sda_m_oe, input sda);
   modport slave  (input scl, output sda_s_oe, input sda);
endinterface
`default_nettype wire

// ### verilog/tws_map.svh
// Purpose: Constants for the two-wire register slave and its master.
// Assumes: 10 MHz mclk; serial clock made by the master from mclk.
// Notes:   All offsets, widths and counts as macros.
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH
`define TWS_DEV_ADDR     7'h5d
`define TWS_REG_AW       8
`define TWS_REG_DW       16
`define TWS_CLK_DIV      8'h20
`define TWS_CLK_MID      8'h10
`define TWS_RD_BIT       1'b1
`define TWS_WR_BIT       1'b0
`endif

// ### verilog/tws_master.sv
// Purpose: Two-wire master doing one word write or read.
// Assumes: Slave is fast; no clock stretching.
// Notes:   Clock made by divider from mclk.
`timescale 1ns/10ps
`default_nettype none
`include "tws_map.svh"
module tws_master #(
   parameter logic [6:0] DEV_ADDR = `TWS_DEV_ADDR
) (
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   tws_if.master                       bus,
   input  wire logic                   req,
   input  wire logic                   rnw,
   input  wire logic [`TWS_REG_AW-1:0] addr,
   input  wire logic [`TWS_REG_DW-1:0] wdata,
   output logic                        ready,
   output logic                        done,
   output logic                        nack,
   output logic [`TWS_REG_DW-1:0]      rdata
);
   typedef struct packed {
      tws_pkg::tws_ms_e         st;
      logic [7:0]               div;
      logic [2:0]               byt;
      logic [3:0]               bit_n;
      logic [8:0]               sh;
      logic                     rd;
      logic                     rs_done;
      logic [7:0]               ra;
      logic [15:0]              wd;
      logic [15:0]              rdv;
      logic                     scl;
      logic                     oe;
      logic                     done;
      logic                     nack;
   } tws_ms_s;
   tws_ms_s r;
   tws_ms_s n;
   logic tick;
   logic mid;
   logic sda_s;
   tws_sync u_sda (.mclk(mclk), .reset_n(reset_n), .d(bus.sda), .q(sda_s));
   assign tick = (r.div == `TWS_CLK_DIV);
   // Data moves in mid-low, well clear of both clock edges
   assign mid  = (r.div == `TWS_CLK_MID);
   function automatic logic [8:0] mk_byte(input tws_ms_s s, input logic [2:0] b);
      case (b)
         3'h0: mk_byte = {DEV_ADDR, `TWS_WR_BIT, 1'b1};
         3'h1: mk_byte = {s.ra, 1'b1};
         3'h2: mk_byte = s.rd ? {DEV_ADDR, `TWS_RD_BIT, 1'b1} : {s.wd[15:8], 1'b1};
         3'h3: mk_byte = s.rd ? 9'h1fe : {s.wd[7:0], 1'b1};
         default: mk_byte = 9'h1ff;
      endcase
   endfunction
   always_comb begin
      n      = r;
      n.div  = tick ? 8'h00 : r.div + 8'h01;
      n.done = 1'b0;
      case (r.st)
         tws_pkg::MS_IDLE: begin
            n.div = 8'h00;
            if (req) begin
               n.rd      = rnw;
               n.ra      = addr;
               n.wd      = wdata;
               n.nack    = 1'b0;
               n.st      = tws_pkg::MS_START;
               n.oe      = 1'b1;
               n.byt     = 3'h0;
               n.rs_done = 1'b0;
            end
         end
         tws_pkg::MS_START: begin
            if (tick) begin
               n.scl   = 1'b0;
               n.sh    = mk_byte(r, r.byt);
               n.bit_n = 4'h0;
               n.st    = tws_pkg::MS_BIT_LO;
            end
         end
         tws_pkg::MS_BIT_LO: begin
            if (mid) begin
               n.oe = ~r.sh[8];
            end
            if (tick) begin
               n.scl = 1'b1;
               n.st  = tws_pkg::MS_BIT_HI;
            end
         end
         tws_pkg::MS_BIT_HI: begin
            if (tick) begin
               n.scl   = 1'b0;
               n.sh    = {r.sh[7:0], 1'b1};
               n.bit_n = r.bit_n + 4'h1;
               n.st    = tws_pkg::MS_BIT_LO;
               if (r.rd && r.rs_done && r.bit_n < 4'h8) begin
                  n.rdv = {r.rdv[14:0], sda_s};
               end
               if (r.bit_n == 4'h8) begin
                  n.bit_n = 4'h0;
                  // Own acknowledge slots of read data are not a refusal
                  if (sda_s && !(r.rd && r.byt >= 3'h3)) begin
                     n.nack = 1'b1;
                     n.st   = tws_pkg::MS_STOP_LO;
                  end else if (r.rd && r.byt == 3'h1) begin
                     n.st = tws_pkg::MS_RS_LO;
                  end else if (r.byt == (r.rd ? 3'h4 : 3'h3)) begin
                     n.st = tws_pkg::MS_STOP_LO;
                  end else begin
                     n.byt = r.byt + 3'h1;
                     n.sh  = mk_byte(r, r.byt + 3'h1);
                  end
               end
            end
         end
         tws_pkg::MS_RS_LO: begin
            if (mid) begin
               n.oe = 1'b0;
            end
            if (tick) begin
               n.scl = 1'b1;
               n.st  = tws_pkg::MS_RS_HI;
            end
         end
         tws_pkg::MS_RS_HI: begin
            if (tick) begin
               n.oe      = 1'b1;
               n.byt     = 3'h2;
               n.rs_done = 1'b1;
               n.st      = tws_pkg::MS_START;
            end
         end
         tws_pkg::MS_STOP_LO: begin
            if (mid) begin
               n.oe = 1'b1;
            end
            if (tick) begin
               n.scl = 1'b1;
               n.st  = tws_pkg::MS_STOP_HI;
            end
         end
         tws_pkg::MS_STOP_HI: begin
            if (tick) begin
               n.oe = 1'b0;
               n.st = tws_pkg::MS_DONE;
            end
         end
         tws_pkg::MS_DONE: begin
            if (tick) begin
               n.done = 1'b1;
               n.st   = tws_pkg::MS_IDLE;
            end
         end
         default: begin
            n.st = tws_pkg::MS_IDLE;
         end
      endcase
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
         r.scl <= 1'b1;
         r.st <= tws_pkg::MS_IDLE;
      end else begin
         r <= n;
      end
   end
   assign bus.scl      = r.scl;
   assign bus.sda_m_oe = r.oe;
   assign ready        = (r.st == tws_pkg::MS_IDLE);
   assign done         = r.done;
   assign nack         = r.nack;
   assign rdata        = r.rdv;
endmodule
`default_nettype wire

// ### verilog/tws_pkg.sv
// Purpose: Types shared by both ends.
// Assumes: Nothing.
// Notes:   Constants live in tws_map.svh.
package tws_pkg;
   typedef enum logic [3:0] {
      SL_IDLE, SL_ADDR, SL_AACK, SL_RADR, SL_RACK, SL_WDAT, SL_WACK,
      SL_RDAT, SL_RDACK, SL_IGN
   } tws_sl_e;
   typedef enum logic [3:0] {
      MS_IDLE, MS_START, MS_BIT_LO, MS_BIT_HI, MS_STOP_LO, MS_STOP_HI,
      MS_RS_LO, MS_RS_HI, MS_DONE
   } tws_ms_e;
endpackage

// ### verilog/tws_slave.sv
// Purpose: Two-wire slave with sixteen-bit register file.
// Assumes: Master drives clock; mclk far faster than link.
// Notes:   Registers held in an array; user port shows write events.
`timescale 1ns/10ps
`default_nettype none
`include "tws_map.svh"
module tws_slave #(
   parameter logic [6:0] DEV_ADDR = `TWS_DEV_ADDR,
   parameter int         NREG     = 256
) (
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   tws_if.slave                        bus,
   output logic                        wr_stb,
   output logic [`TWS_REG_AW-1:0]      wr_addr,
   output logic [`TWS_REG_DW-1:0]      wr_data,
   output logic                        busy
);
   typedef struct packed {
      tws_pkg::tws_sl_e         st;
      logic                     scl_d;
      logic                     sda_d;
      logic [7:0]               sh;
      logic [3:0]               cnt;
      logic                     hi;
      logic [`TWS_REG_AW-1:0]   ra;
      logic [7:0]               msb;
      logic                     oe;
      logic                     stb;
      logic [`TWS_REG_AW-1:0]   wa;
      logic [`TWS_REG_DW-1:0]   wd;
   } tws_sl_s;
   tws_sl_s r;
   tws_sl_s n;
   logic [`TWS_REG_DW-1:0] regs [NREG];
   logic scl_s;
   logic sda_s;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic [7:0] rb;
   tws_sync u_scl (.mclk(mclk), .reset_n(reset_n), .d(bus.scl), .q(scl_s));
   tws_sync u_sda (.mclk(mclk), .reset_n(reset_n), .d(bus.sda), .q(sda_s));
   assign rise  = scl_s & ~r.scl_d;
   assign fall  = ~scl_s & r.scl_d;
   assign start = scl_s & r.scl_d & r.sda_d & ~sda_s;
   assign stop  = scl_s & r.scl_d & ~r.sda_d & sda_s;
   assign rb    = rd_byte(regs[r.ra], r.hi);
   function automatic logic [7:0] rd_byte(input logic [`TWS_REG_DW-1:0] w, input logic hib);
      rd_byte = hib ? w[15:8] : w[7:0];
   endfunction
   always_comb begin
      n       = r;
      n.scl_d = scl_s;
      n.sda_d = sda_s;
      n.stb   = 1'b0;
      if (start) begin
         n.st  = tws_pkg::SL_ADDR;
         n.cnt = 4'h0;
         n.oe  = 1'b0;
      end else if (stop) begin
         n.st = tws_pkg::SL_IDLE;
         n.oe = 1'b0;
      end else begin
         case (r.st)
            tws_pkg::SL_ADDR, tws_pkg::SL_RADR, tws_pkg::SL_WDAT: begin
               if (rise) begin
                  n.sh  = {r.sh[6:0], sda_s};
                  n.cnt = r.cnt + 4'h1;
               end
               if (fall && r.cnt == 4'h8) begin
                  n.cnt = 4'h0;
                  if (r.st == tws_pkg::SL_ADDR) begin
                     if (r.sh[7:1] == DEV_ADDR) begin
                        n.oe = 1'b1;
                        n.st = tws_pkg::SL_AACK;
                        n.hi = 1'b1;
                     end else begin
                        n.st = tws_pkg::SL_IGN;
                     end
                  end else if (r.st == tws_pkg::SL_RADR) begin
                     n.ra = r.sh;
                     n.oe = 1'b1;
                     n.st = tws_pkg::SL_RACK;
                     n.hi = 1'b1;
                  end else begin
                     n.oe = 1'b1;
                     n.st = tws_pkg::SL_WACK;
                     if (r.hi) begin
                        n.msb = r.sh;
                        n.hi  = 1'b0;
                     end else begin
                        n.stb = 1'b1;
                        n.wa  = r.ra;
                        n.wd  = {r.msb, r.sh};
                        n.ra  = r.ra + 8'h01;
                        n.hi  = 1'b1;
                     end
                  end
               end
            end
            tws_pkg::SL_AACK: begin
               if (fall) begin
                  if (r.sh[0] == `TWS_RD_BIT) begin
                     n.st  = tws_pkg::SL_RDAT;
                     n.sh  = rb;
                     n.cnt = 4'h0;
                     n.oe  = ~rb[7];
                  end else begin
                     n.st = tws_pkg::SL_RADR;
                     n.oe = 1'b0;
                  end
               end
            end
            tws_pkg::SL_RACK, tws_pkg::SL_WACK: begin
               if (fall) begin
                  n.oe = 1'b0;
                  n.st = tws_pkg::SL_WDAT;
               end
            end
            tws_pkg::SL_RDAT: begin
               if (fall) begin
                  if (r.cnt == 4'h7) begin
                     n.oe = 1'b0;
                     n.st = tws_pkg::SL_RDACK;
                     if (!r.hi) begin
                        n.ra = r.ra + 8'h01;
                     end
                     n.hi = ~r.hi;
                  end else begin
                     n.sh  = {r.sh[6:0], 1'b0};
                     n.oe  = ~r.sh[6];
                     n.cnt = r.cnt + 4'h1;
                  end
               end
            end
            tws_pkg::SL_RDACK: begin
               if (rise && sda_s) begin
                  n.st = tws_pkg::SL_IGN;
               end else if (fall) begin
                  n.st  = tws_pkg::SL_RDAT;
                  n.sh  = rb;
                  n.cnt = 4'h0;
                  n.oe  = ~rb[7];
               end
            end
            tws_pkg::SL_IDLE, tws_pkg::SL_IGN: begin
               n.oe = 1'b0;
            end
            default: begin
               n.st = tws_pkg::SL_IDLE;
               n.oe = 1'b0;
            end
         endcase
      end
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
         r.scl_d <= 1'b1;
         r.sda_d <= 1'b1;
         r.st <= tws_pkg::SL_IDLE;
      end else begin
         r <= n;
      end
   end
   always_ff @(posedge mclk) begin
      if (r.stb) begin
         regs[r.wa] <= r.wd;
      end
   end
   assign bus.sda_s_oe = r.oe;
   assign wr_stb       = r.stb;
   assign wr_addr      = r.wa;
   assign wr_data      = r.wd;
   assign busy         = (r.st != tws_pkg::SL_IDLE) && (r.st != tws_pkg::SL_IGN);
endmodule
`default_nettype wire

// ### verilog/tws_sync.sv
// Purpose: Three-stage synchroniser with change qualification.
// Assumes: Input from another domain.
// Notes:   Output changes when stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module tws_sync (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic d,
   output logic      q
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } tws_sync_s;
   tws_sync_s st_r;
   tws_sync_s st_nxt;
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) begin
         st_nxt.q = st_r.s3;
      end
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= 4'hf;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign q = st_r.q;
endmodule
`default_nettype wire
